// file: tb/ssdd_rx_model.sv
`default_nettype none

// ----------------------------------------------------------------
// converter side: counts sysref edges, longest clock gap
// ----------------------------------------------------------------
module ssdd_rx_model
(
    input  wire logic   mclk,
    input  wire logic   clr,
    input  wire logic   sref,
    input  wire logic   dclk,
    output logic [7:0]  n_pulse,
    output logic [11:0] max_gap
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sref_q;
    logic        dclk_q;
    logic        seen_q;
    logic [11:0] gap_q;
    wire         rise = dclk && !dclk_q;

    always_ff @(posedge mclk)
    begin
        sref_q <= sref;
        dclk_q <= dclk;
        gap_q  <= rise ? 12'h001 : gap_q + 12'h001;
        if (clr)
        begin
            n_pulse <= 8'h00;
            max_gap <= 12'h000;
            seen_q  <= 1'b0;
        end
        else
        begin
            if (sref && !sref_q)
                n_pulse <= n_pulse + 8'h01;
            if (rise && seen_q && gap_q > max_gap)
                max_gap <= gap_q;
            if (rise)
                seen_q <= 1'b1;
        end
    end
endmodule : ssdd_rx_model

`default_nettype wire

// file: tb/testbench.sv
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench
    import ssdd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n = 0, prog_wr = 0, sync_pin = 0, request_pin = 0;
    logic pol = 0, req_en = 0, plsr_pd = 1, sblk = 1, clr = 1, sref_out;
    logic [10:0] prog_addr = 11'h000;
    logic [7:0]  prog_wdata = 8'h00, prog_rdata, rdat, np0;
    logic [1:0]  smode = SYNC_OFF, src = SRC_RECLK;
    logic [2:0]  blk = 3'h7, dyn_en = 3'h0, dclk_out;
    logic        spd = 0, dse = 0;
    logic [2:0]  hs = 3'h0, cdpd = 3'h0;
    logic [3:0]  tap = 4'h0;
    logic [11:0] mg0, mg1;
    int          n_fail = 0, checks = 0;

    ssdd_top uut (.mclk(mclk), .rst_n(rst_n), .prog_wr(prog_wr),
        .prog_addr(prog_addr), .prog_wdata(prog_wdata),
        .prog_rdata(prog_rdata), .sync_pin(sync_pin),
        .request_pin(request_pin), .sync_polarity_sel(pol),
        .sync_mode(smode), .sref_source_select(src),
        .request_mode_enable(req_en), .pulser_power_down(plsr_pd),
        .sref_power_down(spd), .out_sync_block(blk),
        .sref_divider_sync_block(sblk),
        .device_clk_divide_value({3{10'h008}}),
        .device_clk_coarse_delay({3{10'h008}}),
        .device_clk_half_step(hs), .coarse_delay_power_down(cdpd),
        .dyn_delay_out_enable(dyn_en), .dyn_delay_sref_enable(dse),
        .sref_frame_divider(13'h0014), .sref_divider_offset(13'h0014),
        .local_sref_coarse_delay(tap), .dclk_out(dclk_out),
        .sref_out(sref_out));
    ssdd_rx_model rx0 (.mclk(mclk), .clr(clr), .sref(sref_out),
        .dclk(dclk_out[0]), .n_pulse(np0), .max_gap(mg0));
    ssdd_rx_model rx1 (.mclk(mclk), .clr(clr), .sref(1'b0),
        .dclk(dclk_out[1]), .n_pulse(), .max_gap(mg1));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    task zap;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
    endtask : zap

    task wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge mclk);
        prog_wr = 1'b1;
        prog_addr = a;
        prog_wdata = d;
        @(negedge mclk);
        prog_wr = 1'b0;
    endtask : wr

    task rd(input logic [10:0] a);
        @(negedge mclk);
        prog_addr = a;
        @(negedge mclk);
        rdat = prog_rdata;
    endtask : rd

    task t_reset;
        rd(ADDR_BURST_LEN);
        `CHK(rdat, 8'h00);
        rd(ADDR_DELAY_CLEAR);
        `CHK(rdat[0], 1'b1);
        rd(ADDR_STEP_CNT);
        `CHK(rdat, 8'h00);
        rd(11'h100);
        `CHK(rdat, 8'h00);
        src = SRC_CONT;
        zap;
        cyc(100);
        `CHK(np0, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task t_sync;
        smode = SYNC_PIN;
        blk = 3'h0;
        sblk = 1'b0;
        cyc(2);
        pol = 1'b1;
        cyc(4);
        pol = 1'b0;
        cyc(30);
        blk = 3'h7;
        cdpd = 3'h7;
        sblk = 1'b1;
        zap;
        cyc(40);
        `CHK(mg0, 12'h008);
        `CHK(dclk_out[0], dclk_out[1]);
        $display("test sync done");
    endtask : t_sync

    task t_flush;
        plsr_pd = 1'b0;
        wr(ADDR_DELAY_CLEAR, 8'h01);
        cyc(16);
        rd(ADDR_DELAY_CLEAR);
        `CHK(rdat, 8'h03);
        wr(ADDR_DELAY_CLEAR, 8'h00);
        rd(ADDR_DELAY_CLEAR);
        `CHK(rdat[0], 1'b0);
        zap;
        cyc(200);
        `CHK(np0 >= 8'h09, 1'b1);
        $display("test flush done");
    endtask : t_flush

    task t_burst;
        smode = SYNC_PROG_PULSER;
        src = SRC_PULSER;
        tap = 4'h3;
        cyc(20);
        for (int c = 0; c < 4; c++)
        begin
            zap;
            wr(ADDR_BURST_LEN, 8'(c));
            cyc(300);
            `CHK(np0, 8'h01 << c);
        end
        rd(ADDR_BURST_LEN);
        `CHK(rdat, 8'h03);
        smode = SYNC_PIN_PULSER;
        zap;
        wr(ADDR_BURST_LEN, 8'h01);
        cyc(5);
        sync_pin = 1'b1;
        cyc(5);
        sync_pin = 1'b0;
        cyc(300);
        `CHK(np0, 8'h02);
        $display("test burst done");
    endtask : t_burst

    task t_request;
        smode = SYNC_OFF;
        plsr_pd = 1'b1;
        req_en = 1'b1;
        zap;
        cyc(100);
        `CHK(np0, 8'h00);
        request_pin = 1'b1;
        cyc(200);
        request_pin = 1'b0;
        cyc(100);
        `CHK(np0 >= 8'h09 && np0 <= 8'h0b, 1'b1);
        `CHK(sref_out, 1'b0);
        req_en = 1'b0;
        src = SRC_CONT;
        spd = 1'b1;
        zap;
        cyc(60);
        `CHK(np0, 8'h00);
        spd = 1'b0;
        zap;
        cyc(60);
        `CHK(np0 >= 8'h02, 1'b1);
        $display("test request done");
    endtask : t_request

    task t_dyn;
        logic p;
        p = 1'b1;
        dyn_en = 3'h1;
        dse = 1'b1;
        zap;
        wr(ADDR_STEP_CNT, 8'h02);
        cyc(60);
        `CHK(mg0, 12'h009);
        `CHK(mg1, 12'h008);
        for (int i = 0; i < 20; i++)
        begin
            if (dclk_out[1] === 1'b1 && p === 1'b0)
                break;
            p = dclk_out[1];
            cyc(1);
        end
        `CHK(dclk_out[0], 1'b0);
        cyc(1);
        `CHK(dclk_out[0], 1'b0);
        cyc(1);
        `CHK(dclk_out[0], 1'b1);
        dyn_en = 3'h2;
        wr(ADDR_STEP_CNT, 8'h02);
        cyc(40);
        `CHK(dclk_out[0], dclk_out[1]);
        hs = 3'h2;
        @(posedge dclk_out[0]);
        #1;
        `CHK(dclk_out[1], 1'b0);
        @(negedge mclk);
        #1;
        `CHK(dclk_out[1], 1'b1);
        $display("test dynamic done");
    endtask : t_dyn

    task close_out;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    initial
    begin
        #200000;
        n_fail++;
        close_out;
    end

    initial
    begin
        cyc(20);
        rst_n = 1'b1;
        t_reset;
        t_sync;
        t_flush;
        t_burst;
        t_request;
        t_dyn;
        close_out;
    end
endmodule : testbench

`default_nettype wire

// file: verilog/ssdd_div.sv
`default_nettype none

module ssdd_div
    import ssdd_pkg::*;
#(
    parameter int unsigned W = 10
)
(
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         hold,
    input  wire logic         start,
    input  wire logic         step_load,
    input  wire logic [7:0]   step_count,
    input  wire logic         step_en,
    input  wire logic [W-1:0] div_val,
    input  wire logic [W-1:0] delay_val,
    input  wire logic [W-1:0] alt_val,
    input  wire logic         half_step,
    output logic              clk_out,
    output logic              period_end
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [W-1:0] len_q;
    logic [W-1:0] len_d;
    logic [W-1:0] high_len;
    logic [7:0]   steps_q;
    logic [7:0]   steps_d;
    logic         dly_q;
    logic         dly_d;
    logic         pos_q;
    logic         pos_d;
    logic         neg_q;
    logic         pe_q;
    logic         pe_d;
    logic         wrap;

    // ----------------------------------------------------------------
    // period counter with substituted lengths
    // ----------------------------------------------------------------
    always_comb
    begin
        wrap     = (cnt_q == len_q - 1'b1);
        high_len = {1'b0, div_val[W-1:1]} + W'(div_val[0]);
        cnt_d    = wrap ? '0 : cnt_q + 1'b1;
        len_d    = len_q;
        steps_d  = steps_q;
        dly_d    = dly_q;
        if (wrap)
        begin
            dly_d = 1'b0;
            if (steps_q != 8'h00)
            begin
                len_d   = alt_val;
                steps_d = steps_q - 1'b1;
            end
            else
                len_d = div_val;
        end
        if (step_load)
            steps_d = step_en ? step_count : 8'h00;
        if (hold)
        begin
            cnt_d   = '0;
            len_d   = div_val;
            dly_d   = 1'b0;
            steps_d = 8'h00;
        end
        else if (start)
        begin
            cnt_d = '0;
            len_d = delay_val;
            dly_d = 1'b1;
        end
        pos_d = !hold && !dly_d && (cnt_d < high_len);
        pe_d  = wrap && !hold && !start;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cnt_q   <= '0;
            len_q   <= '1;
            steps_q <= 8'h00;
            dly_q   <= 1'b0;
            pos_q   <= 1'b0;
            pe_q    <= 1'b0;
        end
        else
        begin
            cnt_q   <= cnt_d;
            len_q   <= len_d;
            steps_q <= steps_d;
            dly_q   <= dly_d;
            pos_q   <= pos_d;
            pe_q    <= pe_d;
        end
    end

    // half-period retime for fine delay
    always_ff @(negedge mclk)
    begin
        if (!rst_n)
            neg_q <= 1'b0;
        else
            neg_q <= pos_q;
    end

    assign clk_out    = half_step ? neg_q : pos_q;
    assign period_end = pe_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    step_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        step_load && step_en && !hold |=> steps_q == $past(step_count))
        else $error("step count not loaded on write");

    alt_subst_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wrap && steps_q != 8'h00 && !hold && !start && !step_load
        |=> len_q == $past(alt_val) && steps_q == $past(steps_q) - 1'b1)
        else $error("alternate divide not substituted");

    fixed_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        start && !hold |=> len_q == $past(delay_val) && !pos_q)
        else $error("fixed delay not applied at sync release");

    hold_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
        hold |=> cnt_q == '0 && !pos_q && !pe_q)
        else $error("divider not held in reset during sync");

endmodule : ssdd_div

`default_nettype wire

// file: verilog/ssdd_pkg.sv
`default_nettype none

package ssdd_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int unsigned PROG_AW          = 11;
    localparam logic [10:0] ADDR_BURST_LEN   = 11'h13e;
    localparam logic [10:0] ADDR_DELAY_CLEAR = 11'h143;
    localparam logic [10:0] ADDR_STEP_CNT    = 11'h144;
    localparam int unsigned CLEAR_BIT        = 0;
    localparam int unsigned FLUSHED_BIT      = 1;
    localparam int unsigned BURST_CODE_LSB   = 0;
    localparam int unsigned BURST_CODE_W     = 2;
    localparam logic [7:0]  BURST_LEN_RST    = 8'h00;
    localparam logic [7:0]  STEP_CNT_RST     = 8'h00;
    localparam logic        CLEAR_RST        = 1'b1;

    // ----------------------------------------------------------------
    // timing and limits
    // ----------------------------------------------------------------
    localparam logic [3:0]  CLEAR_HOLD_CYC   = 4'hf;
    localparam logic [9:0]  DDLY_MIN         = 10'h008;
    localparam logic [9:0]  DDLY_MAX         = 10'h3ff;

    // ----------------------------------------------------------------
    // mode encodings
    // ----------------------------------------------------------------
    localparam logic [1:0]  SYNC_OFF         = 2'h0;
    localparam logic [1:0]  SYNC_PIN         = 2'h1;
    localparam logic [1:0]  SYNC_PIN_PULSER  = 2'h2;
    localparam logic [1:0]  SYNC_PROG_PULSER = 2'h3;
    localparam logic [1:0]  SRC_RECLK        = 2'h0;
    localparam logic [1:0]  SRC_SYNC_RECLK   = 2'h1;
    localparam logic [1:0]  SRC_PULSER       = 2'h2;
    localparam logic [1:0]  SRC_CONT         = 2'h3;

    typedef enum logic [1:0] {P_IDLE, P_ARMED, P_BURST} ssdd_pulser_t;

endpackage : ssdd_pkg

`default_nettype wire

// file: verilog/ssdd_top.sv
`default_nettype none

module ssdd_top
    import ssdd_pkg::*;
#(
    parameter int unsigned NDIV  = 3,
    parameter int unsigned DEPTH = 16
)
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              prog_wr,
    input  wire logic [10:0]       prog_addr,
    input  wire logic [7:0]        prog_wdata,
    output logic [7:0]             prog_rdata,
    input  wire logic              sync_pin,
    input  wire logic              request_pin,
    input  wire logic              sync_polarity_sel,
    input  wire logic [1:0]        sync_mode,
    input  wire logic [1:0]        sref_source_select,
    input  wire logic              request_mode_enable,
    input  wire logic              pulser_power_down,
    input  wire logic              sref_power_down,
    input  wire logic [NDIV-1:0]   out_sync_block,
    input  wire logic              sref_divider_sync_block,
    input  wire logic [NDIV*10-1:0] device_clk_divide_value,
    input  wire logic [NDIV*10-1:0] device_clk_coarse_delay,
    input  wire logic [NDIV-1:0]   device_clk_half_step,
    input  wire logic [NDIV-1:0]   coarse_delay_power_down,
    input  wire logic [NDIV-1:0]   dyn_delay_out_enable,
    input  wire logic              dyn_delay_sref_enable,
    input  wire logic [12:0]       sref_frame_divider,
    input  wire logic [12:0]       sref_divider_offset,
    input  wire logic [$clog2(DEPTH)-1:0] local_sref_coarse_delay,
    output logic [NDIV-1:0]        dclk_out,
    output logic                   sref_out
);

    function automatic logic [9:0] ddly_clamp(input logic [9:0] v);
        if (v < DDLY_MIN)
            ddly_clamp = DDLY_MIN;
        else
            ddly_clamp = v;
    endfunction : ddly_clamp

    // ----------------------------------------------------------------
    // pin synchronisers and sync event
    // ----------------------------------------------------------------
    logic sync_meta_q, sync_pin_q, req_meta_q, req_pin_q;
    logic sync_q, sync_d, sync_rise, sync_fall;

    always_comb
    begin
        sync_d    = (sync_pin_q ^ sync_polarity_sel)
                    && (sync_mode != SYNC_OFF);
        sync_rise = sync_d && !sync_q;
        sync_fall = !sync_d && sync_q;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sync_meta_q <= 1'b0;
            sync_pin_q  <= 1'b0;
            req_meta_q  <= 1'b0;
            req_pin_q   <= 1'b0;
            sync_q      <= 1'b0;
        end
        else
        begin
            sync_meta_q <= sync_pin;
            sync_pin_q  <= sync_meta_q;
            req_meta_q  <= request_pin;
            req_pin_q   <= req_meta_q;
            sync_q      <= sync_d;
        end
    end

    // ----------------------------------------------------------------
    // programming registers
    // ----------------------------------------------------------------
    logic [7:0] burst_len_q, burst_len_d, step_q, step_d, rdata_q, rdata_d;
    logic       clear_q, clear_d, step_ld_q, step_ld_d, burst_wr;
    logic       pd_q, flushed;
    logic [3:0] clr_cnt_q, clr_cnt_d;

    always_comb
    begin
        burst_wr    = prog_wr && (prog_addr == ADDR_BURST_LEN);
        burst_len_d = burst_wr ? prog_wdata : burst_len_q;
        step_ld_d   = prog_wr && (prog_addr == ADDR_STEP_CNT);
        step_d      = step_ld_d ? prog_wdata : step_q;
        clear_d     = clear_q;
        if (prog_wr && prog_addr == ADDR_DELAY_CLEAR)
            clear_d = prog_wdata[CLEAR_BIT];
        flushed   = (clr_cnt_q == CLEAR_HOLD_CYC);
        clr_cnt_d = clr_cnt_q;
        if (pd_q && !pulser_power_down)
            clr_cnt_d = 4'h0;
        else if (clear_q && !flushed)
            clr_cnt_d = clr_cnt_q + 1'b1;
        if (clear_d && !clear_q)
            clr_cnt_d = 4'h0;
        case (prog_addr)
            ADDR_BURST_LEN:   rdata_d = burst_len_q;
            ADDR_STEP_CNT:    rdata_d = step_q;
            ADDR_DELAY_CLEAR:
                rdata_d = 8'({flushed, clear_q}) << CLEAR_BIT;
            default:          rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            burst_len_q <= BURST_LEN_RST;
            step_q      <= STEP_CNT_RST;
            step_ld_q   <= 1'b0;
            clear_q     <= CLEAR_RST;
            clr_cnt_q   <= 4'h0;
            pd_q        <= 1'b1;
            rdata_q     <= 8'h00;
        end
        else
        begin
            burst_len_q <= burst_len_d;
            step_q      <= step_d;
            step_ld_q   <= step_ld_d;
            clear_q     <= clear_d;
            clr_cnt_q   <= clr_cnt_d;
            pd_q        <= pulser_power_down;
            rdata_q     <= rdata_d;
        end
    end

    assign prog_rdata = rdata_q;

    // ----------------------------------------------------------------
    // device clock and sysref dividers
    // ----------------------------------------------------------------
    logic sref_clk, sref_pe;

    for (genvar i = 0; i < NDIV; i++)
    begin : g_dclk
        logic [9:0] dv, dly;
        assign dv  = device_clk_divide_value[i*10 +: 10];
        assign dly = coarse_delay_power_down[i] ? dv
                   : ddly_clamp(device_clk_coarse_delay[i*10 +: 10]);
        ssdd_div #(.W(10)) u_div (
            .mclk       (mclk),
            .rst_n      (rst_n),
            .hold       (sync_q && !out_sync_block[i]),
            .start      (sync_fall && !out_sync_block[i]),
            .step_load  (step_ld_q),
            .step_count (step_q),
            .step_en    (dyn_delay_out_enable[i]),
            .div_val    (dv),
            .delay_val  (dly),
            .alt_val    (dv + 10'h001),
            .half_step  (device_clk_half_step[i]),
            .clk_out    (dclk_out[i]),
            .period_end ()
        );

        delay_range_a: assert property (@(posedge mclk)
            disable iff (!rst_n)
            !coarse_delay_power_down[i] |-> dly >= DDLY_MIN && dly <= DDLY_MAX)
            else $error("coarse delay outside its range");
    end

    ssdd_div #(.W(13)) u_sref_div (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .hold       (sync_q && !sref_divider_sync_block),
        .start      (sync_fall && !sref_divider_sync_block),
        .step_load  (step_ld_q),
        .step_count (step_q),
        .step_en    (dyn_delay_sref_enable),
        .div_val    (sref_frame_divider),
        .delay_val  (sref_divider_offset),
        .alt_val    (sref_divider_offset),
        .half_step  (1'b0),
        .clk_out    (sref_clk),
        .period_end (sref_pe)
    );

    // ----------------------------------------------------------------
    // pulser, request gate and source select
    // ----------------------------------------------------------------
    ssdd_pulser_t st_q, st_d;
    logic [3:0]   left_q, left_d;
    logic         gate_q, gate_d, req_q, req_d, sel_q, sel_d;
    logic         pulser_on, req_mode, trig;

    always_comb
    begin
        pulser_on = (sref_source_select == SRC_PULSER) && !pulser_power_down
                    && !request_mode_enable;
        req_mode  = request_mode_enable && (sref_source_select == SRC_PULSER);
        trig = pulser_on
               && ((sync_mode == SYNC_PIN_PULSER && sync_rise)
               || (sync_mode == SYNC_PROG_PULSER && burst_wr));
        st_d   = st_q;
        left_d = left_q;
        case (st_q)
            P_IDLE:  if (trig) st_d = P_ARMED;
            P_ARMED:
                if (sref_pe)
                begin
                    st_d   = P_BURST;
                    left_d = 4'h1 << burst_len_q[BURST_CODE_LSB +:
                             BURST_CODE_W];
                end
            P_BURST:
                if (sref_pe)
                begin
                    left_d = left_q - 1'b1;
                    if (left_q == 4'h1) st_d = P_IDLE;
                end
            default: st_d = P_IDLE;
        endcase
        if (!pulser_on) st_d = P_IDLE;
        gate_d = sref_pe ? (st_d == P_BURST) : gate_q;
        req_d  = sref_pe ? (req_pin_q && req_mode) : req_q;
        if (!req_mode) req_d = 1'b0;
        case (sref_source_select)
            SRC_PULSER: sel_d = sref_clk && (gate_d || req_d);
            SRC_CONT:   sel_d = sref_clk;
            default:    sel_d = sync_q;
        endcase
        if (sref_power_down) sel_d = 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_q   <= P_IDLE;
            left_q <= 4'h0;
            gate_q <= 1'b0;
            req_q  <= 1'b0;
            sel_q  <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            left_q <= left_d;
            gate_q <= gate_d;
            req_q  <= req_d;
            sel_q  <= sel_d;
        end
    end

    // ----------------------------------------------------------------
    // local coarse delay shift buffer
    // ----------------------------------------------------------------
    logic [DEPTH-1:0] shift_q, shift_d;
    logic             out_q, out_d;

    always_comb
    begin
        shift_d = clear_q ? '0 : {shift_q[DEPTH-2:0], sel_q};
        out_d   = clear_q ? 1'b0 : shift_q[local_sref_coarse_delay];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            shift_q <= '0;
            out_q   <= 1'b0;
        end
        else
        begin
            shift_q <= shift_d;
            out_q   <= out_d;
        end
    end

    assign sref_out = out_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    clear_flush_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clear_q |=> !sref_out && shift_q == '0)
        else $error("local delay not flushed while clear set");

    reset_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(rst_n) |-> clear_q && prog_rdata == 8'h00 ##1 clear_q)
        else $error("clear bit not set after reset");

    burst_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q == P_ARMED && sref_pe && pulser_on
        |=> st_q == P_BURST
            && left_q == (4'h1 << $past(burst_len_q[1:0])))
        else $error("burst length not a power of two of the code");

    prog_trigger_a: assert property (@(posedge mclk) disable iff (!rst_n)
        burst_wr && pulser_on && sync_mode == SYNC_PROG_PULSER
        && st_q == P_IDLE |=> st_q == P_ARMED || !pulser_on)
        else $error("burst length write did not start pulser");

    cont_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
        sref_source_select == SRC_CONT && !sref_power_down
        |=> sel_q == $past(sref_clk))
        else $error("continuous sysref interrupted");

    no_runt_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(req_q) && $past(req_mode) |-> $past(sref_pe))
        else $error("request gate changed mid period");

    pin_pulser_a: assert property (@(posedge mclk) disable iff (!rst_n)
        sync_rise && pulser_on && sync_mode == SYNC_PIN_PULSER
        && st_q == P_IDLE |=> st_q == P_ARMED || !pulser_on)
        else $error("pin sync did not start pulser");

    repulse_flush_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pd_q && !pulser_power_down |=> clr_cnt_q == 4'h0 ##1 !flushed)
        else $error("pulser power-up did not restart flush count");

endmodule : ssdd_top

`default_nettype wire
